// *** swa_pkg.sv ***
package swa_pkg;

  // ****************************************************************
  // geometry of the phase map and the aperture delay
  // ****************************************************************
  localparam int TAPS = 24;
  localparam int PICK_W = 4;
  localparam int COARSE_W = 8;
  localparam int FINE_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int EDGE_CNT_W = 2;
  localparam logic [EDGE_CNT_W-1:0] EDGES_FOR_VALID = 2'h3;
  localparam int MAP_LO_BIT = 0;
  localparam int MAP_HI_BIT = TAPS - 1;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CLK_CTRL0 = 12'h029;
  localparam logic [ADDR_W-1:0] OFS_AUTOCAL_ENABLE = 12'h02A;
  localparam logic [ADDR_W-1:0] OFS_AUTOCAL_SETUP = 12'h02B;
  localparam logic [ADDR_W-1:0] OFS_PHASE_MAP_LOW = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_PHASE_MAP_MID = 12'h02D;
  localparam logic [ADDR_W-1:0] OFS_PHASE_MAP_HIGH = 12'h02E;
  localparam logic [ADDR_W-1:0] OFS_AUTOCAL_STATUS = 12'h02F;
  localparam logic [ADDR_W-1:0] OFS_FOUND_INV = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_FOUND_COARSE = 12'h031;
  localparam logic [ADDR_W-1:0] OFS_MANUAL_INV = 12'h032;
  localparam logic [ADDR_W-1:0] OFS_MANUAL_COARSE = 12'h033;
  localparam logic [ADDR_W-1:0] OFS_MANUAL_FINE = 12'h034;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL0_PICK_LSB = 0;
  localparam int CTRL0_FINE_BIT = 4;
  localparam int CTRL0_SINGLE_BIT = 5;
  localparam int STAT_FINISHED_BIT = 0;
  localparam int STAT_NOALIGN_BIT = 1;
  localparam int STAT_MAPVALID_BIT = 2;
  localparam logic [PICK_W-1:0] RST_PICK = 4'h0;
  localparam logic RST_FINE_SPACING = 1'b1;
  localparam logic RST_SINGLE = 1'b0;
  localparam logic [DATA_W-1:0] RST_SETUP = 8'h08;
  localparam logic [COARSE_W-1:0] COARSE_MAX = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic inv;
    logic [COARSE_W-1:0] coarse;
    logic [FINE_W-1:0] fine;
  } swa_tad_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } swa_req_t;

  typedef enum logic [1:0] {
    AC_IDLE = 2'b00,
    AC_SETTLE = 2'b01,
    AC_CHECK = 2'b10,
    AC_DONE = 2'b11
  } swa_state_t;

endpackage

// *** swa_sysref_window_autocal.sv ***
`timescale 1ns/1ps
// Overview of operation
// - capture reference on a deterministic clock edge
// - single-channel mode samples on both clock edges
// - 24-bit phase map flags risky taps
// - map bits 0 and 23 always read one
// - sample pick indexes only taps 0 to 15
// - capture reference at the picked delayed tap
// - spacing bit selects coarse or fine taps
// - map read as three byte registers
// - enable sweeps delay until falling edge aligns
// - finished flag set when search completes
// - found delay readable and kept in use
// - sweep coarse with inversion off and on
// - inversion adds half period, independent of others
module swa_sysref_window_autocal #(
  parameter int TAPS_P = swa_pkg::TAPS
) (
  input wire logic clk, // device clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire swa_pkg::swa_req_t req, // register read/write request
  output logic [swa_pkg::DATA_W-1:0] regRdData, // read data, one cycle late
  input wire logic [TAPS_P-1:0] tapCoarseIn, // reference seen by coarse taps
  input wire logic [TAPS_P-1:0] tapFineIn, // reference seen by fine taps
  input wire logic refFallIn, // reference seen at falling clock edge
  input wire logic alignAheadIn, // reference rise precedes clock fall
  output logic tapFineSpacing, // selects fine tap delay line
  output logic sysrefCapture, // captured reference level
  output logic sysrefCaptureEdge, // pulse on captured rising edge
  output swa_pkg::swa_tad_t tadOut // aperture delay in use
);
  import swa_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [TAPS_P-1:0] coarseMeta, coarseSync;
  logic [TAPS_P-1:0] fineMeta, fineSync;
  logic fallMeta, fallSync, alignMeta, alignSync;

  // two flops on every asynchronous tap sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coarseMeta <= '0;
      coarseSync <= '0;
      fineMeta <= '0;
      fineSync <= '0;
      fallMeta <= 1'b0;
      fallSync <= 1'b0;
      alignMeta <= 1'b0;
      alignSync <= 1'b0;
    end else if (ce) begin
      coarseMeta <= tapCoarseIn;
      coarseSync <= coarseMeta;
      fineMeta <= tapFineIn;
      fineSync <= fineMeta;
      fallMeta <= refFallIn;
      fallSync <= fallMeta;
      alignMeta <= alignAheadIn;
      alignSync <= alignMeta;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [PICK_W-1:0] samplePick;
  logic singleChannel, autocalEnable, acLoad, bestValid, bestInv;
  logic [DATA_W-1:0] autocalSetup;
  logic [COARSE_W-1:0] bestCoarse;
  swa_tad_t tadManual;
  swa_state_t state;

  // writes; the search result overrides a simultaneous software write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      samplePick <= RST_PICK;
      tapFineSpacing <= RST_FINE_SPACING;
      singleChannel <= RST_SINGLE;
      autocalEnable <= 1'b0;
      autocalSetup <= RST_SETUP;
      tadManual <= '0;
    end else if (ce) begin
      if (req.wrEn) begin
        unique case (req.addr)
          OFS_CLK_CTRL0: begin
            samplePick <= req.wrData[CTRL0_PICK_LSB +: PICK_W];
            tapFineSpacing <= req.wrData[CTRL0_FINE_BIT];
            singleChannel <= req.wrData[CTRL0_SINGLE_BIT];
          end
          OFS_AUTOCAL_ENABLE: autocalEnable <= req.wrData[0];
          OFS_AUTOCAL_SETUP: autocalSetup <= req.wrData;
          OFS_MANUAL_INV: tadManual.inv <= req.wrData[0];
          OFS_MANUAL_COARSE: tadManual.coarse <= req.wrData;
          OFS_MANUAL_FINE: tadManual.fine <= req.wrData;
          default: ;
        endcase
      end
      // found setting becomes the standing setting, kept after disable
      if (acLoad && bestValid) begin
        tadManual.inv <= bestInv;
        tadManual.coarse <= bestCoarse;
      end
    end
  end

  // ****************************************************************
  // capture at the picked tap
  // ****************************************************************
  logic [TAPS_P-1:0] tapSel;
  logic pickSample, captureNow;
  logic [EDGE_CNT_W-1:0] edgeCount;

  assign tapSel = tapFineSpacing ? fineSync : coarseSync;
  assign pickSample = tapSel[samplePick];
  // dual-edge sampling widens the capture window by half a period
  assign captureNow = singleChannel ? (pickSample | fallSync)
                                    : pickSample;

  // registered capture so every reference edge lands on one clock edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sysrefCapture <= 1'b0;
      sysrefCaptureEdge <= 1'b0;
    end else if (ce) begin
      sysrefCapture <= captureNow;
      sysrefCaptureEdge <= captureNow & ~sysrefCapture;
    end
  end

  // ****************************************************************
  // phase map
  // ****************************************************************
  logic [TAPS_P-1:0] risk, riskAcc, phaseMap;

  // a tap is risky when it disagrees with a neighbour
  always_comb begin
    risk = '0;
    for (int i = 1; i < TAPS_P - 1; i++) begin
      risk[i] = (tapSel[i] ^ tapSel[i-1]) | (tapSel[i] ^ tapSel[i+1]);
    end
    risk[MAP_LO_BIT] = 1'b1;
    risk[MAP_HI_BIT] = 1'b1;
  end

  // the map is rebuilt between successive edges, so it tracks drift
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      riskAcc <= '0;
      phaseMap <= '1;
      edgeCount <= '0;
    end else if (ce) begin
      if (sysrefCaptureEdge) begin
        phaseMap <= riskAcc | risk;
        riskAcc <= '0;
        if (edgeCount != EDGES_FOR_VALID) begin
          edgeCount <= edgeCount + 1'b1;
        end
      end else begin
        riskAcc <= riskAcc | risk;
      end
    end
  end

  // ****************************************************************
  // automatic calibration search
  // ****************************************************************
  logic acInv, prevAhead, firstStep;
  logic [COARSE_W-1:0] acCoarse;
  logic [DATA_W-1:0] settleCnt;

  // one sweep per polarity; the smaller found coarse delay wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= AC_IDLE;
      acInv <= 1'b0;
      acCoarse <= '0;
      prevAhead <= 1'b0;
      firstStep <= 1'b1;
      settleCnt <= '0;
      bestValid <= 1'b0;
      bestInv <= 1'b0;
      bestCoarse <= '0;
      acLoad <= 1'b0;
    end else if (ce) begin
      acLoad <= 1'b0;
      if (!autocalEnable) begin
        state <= AC_IDLE;
      end else begin
        unique case (state)
          AC_IDLE: begin
            acInv <= 1'b0;
            acCoarse <= '0;
            firstStep <= 1'b1;
            bestValid <= 1'b0;
            settleCnt <= autocalSetup;
            state <= AC_SETTLE;
          end
          AC_SETTLE: begin
            if (settleCnt == DATA_ZERO) begin
              state <= AC_CHECK;
            end else begin
              settleCnt <= settleCnt - 1'b1;
            end
          end
          AC_CHECK: begin
            settleCnt <= autocalSetup;
            state <= AC_SETTLE;
            if ((!firstStep && !prevAhead && alignSync) ||
                acCoarse == COARSE_MAX) begin
              // polarity finished: keep a hit if it beats the best
              if (!firstStep && !prevAhead && alignSync &&
                  (!bestValid || acCoarse < bestCoarse)) begin
                bestValid <= 1'b1;
                bestInv <= acInv;
                bestCoarse <= acCoarse;
              end
              if (!acInv) begin
                acInv <= 1'b1;
                acCoarse <= '0;
                firstStep <= 1'b1;
              end else begin
                state <= AC_DONE;
                acLoad <= 1'b1;
              end
            end else begin
              acCoarse <= acCoarse + 1'b1;
              prevAhead <= alignSync;
              firstStep <= 1'b0;
            end
          end
          AC_DONE: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // delay drive
  // ****************************************************************
  // while sweeping the trial setting drives the line, else the standing one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tadOut <= '0;
    end else if (ce) begin
      if (state == AC_SETTLE || state == AC_CHECK) begin
        tadOut.inv <= acInv;
        tadOut.coarse <= acCoarse;
        tadOut.fine <= tadManual.fine;
      end else begin
        tadOut <= tadManual;
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [DATA_W-1:0] next_regRdData;

  // unmapped offsets read zero
  always_comb begin
    next_regRdData = DATA_ZERO;
    unique case (req.addr)
      OFS_CLK_CTRL0: begin
        next_regRdData[CTRL0_PICK_LSB +: PICK_W] = samplePick;
        next_regRdData[CTRL0_FINE_BIT] = tapFineSpacing;
        next_regRdData[CTRL0_SINGLE_BIT] = singleChannel;
      end
      OFS_AUTOCAL_ENABLE: next_regRdData[0] = autocalEnable;
      OFS_AUTOCAL_SETUP: next_regRdData = autocalSetup;
      OFS_PHASE_MAP_LOW: next_regRdData = phaseMap[7:0];
      OFS_PHASE_MAP_MID: next_regRdData = phaseMap[15:8];
      OFS_PHASE_MAP_HIGH: next_regRdData = phaseMap[23:16];
      OFS_AUTOCAL_STATUS: begin
        next_regRdData[STAT_FINISHED_BIT] = (state == AC_DONE);
        next_regRdData[STAT_NOALIGN_BIT] = (state == AC_DONE) & ~bestValid;
        next_regRdData[STAT_MAPVALID_BIT] = (edgeCount == EDGES_FOR_VALID);
      end
      OFS_FOUND_INV: next_regRdData[0] = bestInv;
      OFS_FOUND_COARSE: next_regRdData = bestCoarse;
      OFS_MANUAL_INV: next_regRdData[0] = tadManual.inv;
      OFS_MANUAL_COARSE: next_regRdData = tadManual.coarse;
      OFS_MANUAL_FINE: next_regRdData = tadManual.fine;
      default: next_regRdData = DATA_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= DATA_ZERO;
    end else if (ce && req.rdEn) begin
      regRdData <= next_regRdData;
    end
  end

endmodule

// *** swa_autocal_asserts.sv ***
`timescale 1ns/1ps
// ****************************************************************
// port checks for the reference window and autocal block
// ****************************************************************
module swa_autocal_asserts #(
  parameter int TAPS_P = swa_pkg::TAPS
) (
  input wire logic clk, // device clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire swa_pkg::swa_req_t req, // register request
  input wire logic [swa_pkg::DATA_W-1:0] regRdData, // read data
  input wire logic [TAPS_P-1:0] tapCoarseIn, // coarse taps
  input wire logic [TAPS_P-1:0] tapFineIn, // fine taps
  input wire logic refFallIn, // reference at falling edge
  input wire logic alignAheadIn, // alignment detector
  input wire logic tapFineSpacing, // fine taps in use
  input wire logic sysrefCapture, // captured reference
  input wire logic sysrefCaptureEdge, // captured rising edge
  input wire swa_pkg::swa_tad_t tadOut // delay in use
);
  import swa_pkg::*;
  logic acOn;
  logic [1:0] acHist;
  logic rdOn;
  logic wrTad;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // requests as the block takes them
  assign rdOn = ce && req.rdEn;
  assign wrTad = ce && req.wrEn && req.addr inside
    {OFS_MANUAL_INV, OFS_MANUAL_COARSE, OFS_MANUAL_FINE};
  // enable as written; the history gives tadOut time to fall back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acOn <= 1'b0;
      acHist <= 2'b00;
    end else if (ce) begin
      acHist <= {acHist[0], acOn};
      if (req.wrEn && req.addr == OFS_AUTOCAL_ENABLE) begin
        acOn <= req.wrData[0];
      end
    end
  end
  edge_on_rise_a: assert property (
    sysrefCaptureEdge && $past(ce) |-> sysrefCapture && !$past(sysrefCapture))
    else $error("edge pulse without a capture rise");
  edge_single_a: assert property (
    ce && sysrefCaptureEdge |=> !sysrefCaptureEdge)
    else $error("edge pulse longer than one cycle");
  rise_has_edge_a: assert property (
    $rose(sysrefCapture) |-> sysrefCaptureEdge)
    else $error("capture rose without edge pulse");
  map_low_end_a: assert property (
    rdOn && req.addr == OFS_PHASE_MAP_LOW |=> regRdData[0])
    else $error("lowest map bit read as zero");
  map_high_end_a: assert property (
    rdOn && req.addr == OFS_PHASE_MAP_HIGH |=> regRdData[7])
    else $error("highest map bit read as zero");
  spacing_write_a: assert property (
    ce && req.wrEn && req.addr == OFS_CLK_CTRL0
    |=> tapFineSpacing == $past(req.wrData[CTRL0_FINE_BIT]))
    else $error("spacing bit did not follow write");
  read_hold_a: assert property (
    !rdOn |=> $stable(regRdData))
    else $error("read data moved without a read");
  tad_hold_a: assert property (
    !acOn && acHist == 2'b00 && !wrTad && !$past(wrTad)
    |=> $stable(tadOut))
    else $error("delay in use moved on its own");
  cover property (sysrefCaptureEdge);
  cover property ($fell(acOn));
  cover property (rdOn && req.addr == OFS_AUTOCAL_STATUS
    ##1 regRdData[STAT_FINISHED_BIT]);
endmodule
bind swa_sysref_window_autocal swa_autocal_asserts #(.TAPS_P(TAPS_P)) u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .req(req), .regRdData(regRdData),
  .tapCoarseIn(tapCoarseIn), .tapFineIn(tapFineIn), .refFallIn(refFallIn),
  .alignAheadIn(alignAheadIn), .tapFineSpacing(tapFineSpacing),
  .sysrefCapture(sysrefCapture), .sysrefCaptureEdge(sysrefCaptureEdge),
  .tadOut(tadOut));

// *** swa_ref_source_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// periodic reference source and alignment detector
// ****************************************************************
module swa_ref_source_model #(
  parameter int PERIOD = 16, // reference period in clocks
  parameter int HIGH = 8, // clocks the reference stays high
  parameter int K_COARSE = 10, // first coarse tap seeing the late copy
  parameter int K_FINE = 5, // first fine tap seeing the late copy
  parameter logic [7:0] TGT0 = 8'h28, // coarse where inv 0 aligns
  parameter logic [7:0] TGT1 = 8'h14 // coarse where inv 1 aligns
) (
  input wire logic clk, // device clock
  input wire logic nrst, // async reset, active low
  input wire logic run, // start the reference
  input wire logic alignNever, // detector never reports alignment
  input wire swa_pkg::swa_tad_t tadOut, // delay applied by the device
  output logic refLevel, // reference as launched
  output logic [swa_pkg::TAPS-1:0] tapCoarseIn, // coarse tap view
  output logic [swa_pkg::TAPS-1:0] tapFineIn, // fine tap view
  output logic refFallIn, // reference one clock early
  output logic alignAheadIn // rise ahead of clock fall
);
  import swa_pkg::*;
  int cnt;
  logic refLate;
  // stays low until started, then never stops, so edges keep coming
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      refLevel <= 1'b0;
      refLate <= 1'b0;
      refFallIn <= 1'b0;
    end else if (run) begin
      cnt <= (cnt + 1) % PERIOD;
      refLevel <= ((cnt + 1) % PERIOD) < HIGH;
      refFallIn <= ((cnt + 2) % PERIOD) < HIGH;
      refLate <= refLevel;
    end
  end
  // a skew split: taps at and above it see the reference one clock late
  always_comb begin
    for (int i = 0; i < TAPS; i++) begin
      tapCoarseIn[i] = (i < K_COARSE) ? refLevel : refLate;
      tapFineIn[i] = (i < K_FINE) ? refLevel : refLate;
    end
  end
  // alignment reached once the trial coarse meets its polarity target
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alignAheadIn <= 1'b0;
    end else begin
      alignAheadIn <= !alignNever &&
        (tadOut.coarse >= (tadOut.inv ? TGT1 : TGT0));
    end
  end
endmodule

// *** tb_sysref_window_autocal.sv ***
`timescale 1ns/1ps
// ****************************************************************
// register-level bench for the reference window and autocal block
// ****************************************************************
module tb_sysref_window_autocal;
  import swa_pkg::*;
  localparam int K_FINE = 5;
  localparam int K_COARSE = 10;
  localparam logic [7:0] TGT1 = 8'h14;
  localparam logic [23:0] MAP_F = 24'h80_0001 | (24'h3 << (K_FINE - 1));
  localparam logic [23:0] MAP_C = 24'h80_0001 | (24'h3 << (K_COARSE - 1));
  logic clk;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic run = 1'b0;
  logic alignNever = 1'b0;
  swa_req_t req = '0;
  logic [DATA_W-1:0] regRdData;
  logic [TAPS-1:0] tapCoarseIn;
  logic [TAPS-1:0] tapFineIn;
  logic refFallIn;
  logic alignAheadIn;
  logic tapFineSpacing;
  logic sysrefCapture;
  logic sysrefCaptureEdge;
  logic refLevel;
  swa_tad_t tadOut;
  logic [DATA_W-1:0] rdv;
  int n_fail = 0;
  int n_compared = 0;
  int n;
  int picks[4] = '{0, 4, 5, 15};
  swa_sysref_window_autocal DUT (.clk(clk), .nrst(nrst), .ce(ce), .req(req),
    .regRdData(regRdData), .tapCoarseIn(tapCoarseIn), .tapFineIn(tapFineIn),
    .refFallIn(refFallIn), .alignAheadIn(alignAheadIn),
    .tapFineSpacing(tapFineSpacing), .sysrefCapture(sysrefCapture),
    .sysrefCaptureEdge(sysrefCaptureEdge), .tadOut(tadOut));
  swa_ref_source_model #(.K_COARSE(K_COARSE), .K_FINE(K_FINE), .TGT1(TGT1))
    u_src (.clk(clk), .nrst(nrst), .run(run), .alignNever(alignNever),
    .tadOut(tadOut), .refLevel(refLevel), .tapCoarseIn(tapCoarseIn),
    .tapFineIn(tapFineIn), .refFallIn(refFallIn),
    .alignAheadIn(alignAheadIn));
  // 10 MHz device clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // inputs move a fixed 10 ns after each rising edge
  task automatic tick();
    @(posedge clk);
    #10;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req.wrEn = 1'b1;
    req.addr = a;
    req.wrData = d;
    tick();
    req.wrEn = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    req.rdEn = 1'b1;
    req.addr = a;
    tick();
    req.rdEn = 1'b0;
    rdv = regRdData;
    tick();
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rd(a);
    chk(24'(rdv), 24'(e));
  endtask
  // the three map bytes, smallest delay at the lowest offset
  task automatic mapchk(input logic [23:0] m);
    for (int b = 0; b < 3; b++) begin
      rdchk(ADDR_W'(OFS_PHASE_MAP_LOW + b), m[8*b +: 8]);
    end
  endtask
  // clocks from a launched reference rise to the captured edge pulse
  task automatic meas(output int lag);
    int k;
    for (k = 0; k < 64 && refLevel !== 1'b0; k++) tick();
    for (k = 0; k < 64 && refLevel !== 1'b1; k++) tick();
    for (lag = 0; lag < 20 && sysrefCaptureEdge !== 1'b1; lag++) tick();
  endtask
  // bounded poll of the finished flag
  task automatic poll();
    rdv = '0;
    for (int k = 0; k < 6000 && rdv[0] !== 1'b1; k++) rd(OFS_AUTOCAL_STATUS);
  endtask
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the longest sweep
  initial begin
    #(20000 * 100);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    #10;
    nrst = 1'b1;
    wr(12'h0FF, 8'h55);
    rdchk(12'h0FF, DATA_ZERO);
    wr(OFS_PHASE_MAP_LOW, 8'h00);
    mapchk(24'hFF_FFFF);
    rdchk(OFS_AUTOCAL_STATUS, 8'h00);
    run = 1'b1;
    repeat (80) tick();
    rdchk(OFS_AUTOCAL_STATUS, 8'h04);
    mapchk(MAP_F);
    wr(OFS_CLK_CTRL0, 8'h00);
    chk(24'(tapFineSpacing), 24'h0);
    repeat (80) tick();
    mapchk(MAP_C);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CLK_CTRL0, 8'(16 + picks[i]));
      meas(n);
      chk(24'(n), 24'(3 + (picks[i] >= K_FINE)));
      chk(24'(sysrefCapture), 24'h1);
    end
    wr(OFS_CLK_CTRL0, 8'h30);
    meas(n);
    chk(24'(n), 24'h2);
    wr(OFS_CLK_CTRL0, 8'h10);
    wr(OFS_AUTOCAL_SETUP, 8'h08);
    wr(OFS_AUTOCAL_ENABLE, 8'h01);
    poll();
    rdchk(OFS_AUTOCAL_STATUS, 8'h05);
    rdchk(OFS_FOUND_INV, 8'h01);
    rdchk(OFS_FOUND_COARSE, TGT1);
    chk(24'(tadOut), 24'({1'b1, TGT1, 8'h00}));
    wr(OFS_AUTOCAL_ENABLE, 8'h00);
    rdchk(OFS_AUTOCAL_STATUS, 8'h04);
    chk(24'(tadOut), 24'({1'b1, TGT1, 8'h00}));
    wr(OFS_MANUAL_FINE, 8'h5A);
    wr(OFS_MANUAL_COARSE, 8'h07);
    chk(24'(tadOut), 24'({1'b1, 8'h07, 8'h5A}));
    alignNever = 1'b1;
    wr(OFS_AUTOCAL_ENABLE, 8'h01);
    poll();
    rdchk(OFS_AUTOCAL_STATUS, 8'h07);
    chk(24'(tadOut), 24'({1'b1, 8'h07, 8'h5A}));
    // a write while the clock enable is low must be swallowed
    ce = 1'b0;
    wr(OFS_MANUAL_FINE, 8'h11);
    ce = 1'b1;
    rdchk(OFS_MANUAL_FINE, 8'h5A);
    chk(24'(tadOut), 24'({1'b1, 8'h07, 8'h5A}));
    end_of_test();
  end
endmodule
